// ===== include/ipdma_pkg.sv
// Package: constants and types for the ISA DMA channel passing bridge
`default_nettype none
package ipdma_pkg;
	localparam logic [7:0] IPDMA_CHANNELS = 8'h08;
	localparam logic [2:0] IPDMA_RSVD_CHANNEL = 3'h4;
	localparam logic [2:0] IPDMA_GNT_BITS = 3'h3;
	localparam logic [31:0] IPDMA_ADDR_NORMAL = 32'h0000_0000;
	localparam logic [31:0] IPDMA_ADDR_NORMAL_TC = 32'h0000_0004;
	localparam logic [31:0] IPDMA_ADDR_VERIFY = 32'h0000_00C0;
	localparam logic [31:0] IPDMA_ADDR_VERIFY_TC = 32'h0000_00C4;
	localparam int IPDMA_TC_BIT = 2;
	localparam logic [2:0] IPDMA_DIV3_CODE = 3'h2;
	localparam logic [2:0] IPDMA_DIV4_CODE = 3'h3;
	localparam logic [2:0] IPDMA_DIV_RESET = 3'h3;
	// AXI register map
	localparam logic [7:0] IPDMA_REG_CTRL = 8'h00;
	localparam logic [7:0] IPDMA_REG_STATUS = 8'h04;
	localparam int IPDMA_CTRL_DIV_LSB = 0;
	localparam int IPDMA_CTRL_BOOTDONE_BIT = 4;
	localparam logic [1:0] IPDMA_RESP_OKAY = 2'h0;
	localparam logic [1:0] IPDMA_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {IPDMA_CYC_NONE, IPDMA_CYC_READ, IPDMA_CYC_WRITE, IPDMA_CYC_VERIFY}
		ipdma_cyc_t;
endpackage : ipdma_pkg
`default_nettype wire

// ===== src/ipdma_clkdiv.sv
// ISA bus clock divider, divide by three or four
`timescale 1ns/1ps
`default_nettype none
module ipdma_clkdiv
	import ipdma_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [2:0] div_code,
	output logic isa_clk
);
	logic [1:0] count;
	wire [1:0] last_count = (div_code == IPDMA_DIV3_CODE) ? 2'h2 : 2'h3;
	// Invalid codes fall back to divide by four rather than stopping the clock
	wire [1:0] high_count = (div_code == IPDMA_DIV3_CODE) ? 2'h1 : 2'h2;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count <= 2'h0;
			isa_clk <= 1'b0;
		end else begin
			count <= (count >= last_count) ? 2'h0 : count + 2'h1;
			isa_clk <= ((count >= last_count) ? 2'h0 : count + 2'h1) < high_count;
		end
	end
endmodule : ipdma_clkdiv
`default_nettype wire

// ===== src/ipdma_axil.sv
// AXI4-Lite slave holding control and status words
`timescale 1ns/1ps
`default_nettype none
module ipdma_axil
	import ipdma_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [31:0] status,
	output logic [31:0] ctrl
);
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire do_write = aw_held && w_held && !bvalid;
	wire do_read = arvalid && arready;
	wire [31:0] next_ctrl = (ctrl & ~{{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
		{8{w_strb[0]}}}) | (w_data & {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}},
		{8{w_strb[0]}}});
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= IPDMA_RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= IPDMA_RESP_OKAY;
			ctrl <= {29'h0, IPDMA_DIV_RESET};
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				awready <= 1'b0;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				wready <= 1'b0;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
				bvalid <= 1'b1;
				bresp <= (aw_addr[7:2] == IPDMA_REG_CTRL[7:2]) ? IPDMA_RESP_OKAY : IPDMA_RESP_SLVERR;
				if (aw_addr[7:2] == IPDMA_REG_CTRL[7:2])
					ctrl <= next_ctrl;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			arready <= arvalid && !arready && !rvalid;
			if (do_read) begin
				rvalid <= 1'b1;
				rresp <= IPDMA_RESP_OKAY;
				if (araddr[7:2] == IPDMA_REG_CTRL[7:2]) begin
					rdata <= ctrl;
				end else if (araddr[7:2] == IPDMA_REG_STATUS[7:2]) begin
					rdata <= status;
				end else begin
					rdata <= 32'h0000_0000;
					rresp <= IPDMA_RESP_SLVERR;
				end
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end
	// Write ready flags are flops mirroring the held flags and arready is a flop too, so no bus output is combinational
endmodule : ipdma_axil
`default_nettype wire

// ===== src/ipdma_bridge.sv
// Top: serial DMA request/grant passing, DMA I/O decode, boot decode, ISA clock
`timescale 1ns/1ps
`default_nettype none
module ipdma_bridge
	import ipdma_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [7:0] ISA_DMA_REQUEST,
	output logic SERIAL_DMA_REQUEST_N,
	input wire logic SERIAL_DMA_GRANT_N,
	output logic [7:0] ISA_DMA_ACKNOWLEDGE_N,
	input wire logic DMA_DONE,
	input wire logic IO_CYCLE_VALID,
	input wire logic IO_CYCLE_WRITE,
	input wire logic [31:0] IO_CYCLE_ADDR,
	output logic ISA_DMA_READ,
	output logic ISA_DMA_WRITE,
	output logic ISA_DMA_VERIFY,
	output logic ISA_DMA_TC,
	input wire logic MEM_CYCLE_VALID,
	input wire logic MEM_IN_BIOS_RANGE,
	input wire logic MEM_CLAIMED_ELSEWHERE,
	input wire logic SUBTRACTIVE_DECODE_INHIBIT,
	input wire logic BOOT_POSITIVE_DECODE_TEST_N,
	output logic FORWARD_TO_ISA,
	output logic ISA_BUS_CLOCK,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	import ipdma_pkg::*;

	typedef enum logic [1:0] {IPDMA_REQ_IDLE, IPDMA_REQ_START, IPDMA_REQ_BITS, IPDMA_REQ_HOLD}
		ipdma_req_t;
	typedef enum logic [1:0] {IPDMA_GNT_IDLE, IPDMA_GNT_CODE} ipdma_gnt_t;

	// Request, grant, inhibit and boot test pins pass two flip-flops before any logic reads them
	logic [7:0] isa_dma_request_meta;
	logic [7:0] isa_dma_request;
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	wire gnt_n = pin_sync[0];
	wire inhibit = pin_sync[1];
	wire boot_test = !pin_sync[2];

	ipdma_req_t req_state;
	ipdma_gnt_t gnt_state;
	logic [2:0] bit_count;
	logic [7:0] req_shift;
	logic [2:0] gnt_code;
	logic [1:0] gnt_count;
	logic granted;
	logic [2:0] granted_chan;
	logic [31:0] ctrl;
	logic isa_clk;

	// Channel 4 is never passed
	wire [7:0] passed_req = isa_dma_request & ~(8'h01 << IPDMA_RSVD_CHANNEL);
	wire any_req = |passed_req;
	wire [2:0] next_code = {gnt_code[1:0], gnt_n};
	wire code_done = (gnt_state == IPDMA_GNT_CODE) && (gnt_count == IPDMA_GNT_BITS[1:0] - 2'h1);
	wire code_valid = next_code != IPDMA_RSVD_CHANNEL;
	wire boot_done = ctrl[IPDMA_CTRL_BOOTDONE_BIT];

	// DMA I/O decode; bits 7:6 pick normal or verify, bit 2 is terminal count, all other bits must be zero
	wire addr_hi_zero = (IO_CYCLE_ADDR & ~32'h0000_00C4) == 32'h0000_0000;
	wire hit_normal = addr_hi_zero && (IO_CYCLE_ADDR[7:6] == IPDMA_ADDR_NORMAL[7:6]);
	wire hit_verify = addr_hi_zero && (IO_CYCLE_ADDR[7:6] == IPDMA_ADDR_VERIFY[7:6]) && !IO_CYCLE_WRITE;
	wire cyc_is_tc = IO_CYCLE_ADDR[IPDMA_TC_BIT];
	wire dma_cycle = granted && IO_CYCLE_VALID && (hit_normal || hit_verify);
	ipdma_cyc_t cyc_kind;
	assign cyc_kind = !dma_cycle ? IPDMA_CYC_NONE
		: hit_verify ? IPDMA_CYC_VERIFY
		: IO_CYCLE_WRITE ? IPDMA_CYC_WRITE : IPDMA_CYC_READ;

	// During boot test, until the boot-done bit is set, the inhibit input is a don't care for the BIOS range
	wire bios_boot = boot_test && !boot_done && MEM_IN_BIOS_RANGE;
	wire next_forward = MEM_CYCLE_VALID && (bios_boot
		|| (!MEM_CLAIMED_ELSEWHERE && !inhibit));

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			isa_dma_request_meta <= 8'h00;
			isa_dma_request <= 8'h00;
			pin_meta <= 3'h7;
			pin_sync <= 3'h7;
		end else begin
			isa_dma_request_meta <= ISA_DMA_REQUEST;
			isa_dma_request <= isa_dma_request_meta;
			pin_meta <= {BOOT_POSITIVE_DECODE_TEST_N, SUBTRACTIVE_DECODE_INHIBIT, SERIAL_DMA_GRANT_N};
			pin_sync <= pin_meta;
		end
	end

	// Serial request transmitter
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			req_state <= IPDMA_REQ_IDLE;
			bit_count <= 3'h0;
			req_shift <= 8'h00;
			SERIAL_DMA_REQUEST_N <= 1'b1;
		end else begin
			case (req_state)
				IPDMA_REQ_IDLE: begin
					SERIAL_DMA_REQUEST_N <= 1'b1;
					if (any_req) begin
						SERIAL_DMA_REQUEST_N <= 1'b0;
						req_shift <= passed_req;
						bit_count <= 3'h0;
						req_state <= IPDMA_REQ_START;
					end
				end
				IPDMA_REQ_START, IPDMA_REQ_BITS: begin
					// Request bits are active high on the line, channel 0 first
					SERIAL_DMA_REQUEST_N <= req_shift[0];
					req_shift <= {1'b0, req_shift[7:1]};
					bit_count <= bit_count + 3'h1;
					req_state <= (bit_count == 3'h7) ? IPDMA_REQ_HOLD : IPDMA_REQ_BITS;
				end
				IPDMA_REQ_HOLD: begin
					SERIAL_DMA_REQUEST_N <= !any_req;
					if (!any_req)
						req_state <= IPDMA_REQ_IDLE;
				end
				default: begin
					req_state <= IPDMA_REQ_IDLE;
					SERIAL_DMA_REQUEST_N <= 1'b1;
				end
			endcase
		end
	end

	// Serial grant receiver and acknowledge
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			gnt_state <= IPDMA_GNT_IDLE;
			gnt_code <= 3'h0;
			gnt_count <= 2'h0;
			granted <= 1'b0;
			granted_chan <= 3'h0;
			ISA_DMA_ACKNOWLEDGE_N <= 8'hFF;
		end else begin
			if (DMA_DONE) begin
				granted <= 1'b0;
				ISA_DMA_ACKNOWLEDGE_N <= 8'hFF;
			end
			case (gnt_state)
				IPDMA_GNT_IDLE: begin
					gnt_count <= 2'h0;
					if (!gnt_n)
						gnt_state <= IPDMA_GNT_CODE;
				end
				IPDMA_GNT_CODE: begin
					gnt_code <= next_code;
					gnt_count <= gnt_count + 2'h1;
					if (code_done) begin
						gnt_state <= IPDMA_GNT_IDLE;
						if (code_valid) begin
							granted <= 1'b1;
							granted_chan <= next_code;
							ISA_DMA_ACKNOWLEDGE_N <= ~(8'h01 << next_code);
						end
					end
				end
				default: gnt_state <= IPDMA_GNT_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ISA_DMA_READ <= 1'b0;
			ISA_DMA_WRITE <= 1'b0;
			ISA_DMA_VERIFY <= 1'b0;
			ISA_DMA_TC <= 1'b0;
			FORWARD_TO_ISA <= 1'b0;
			ISA_BUS_CLOCK <= 1'b0;
		end else begin
			ISA_DMA_READ <= cyc_kind == IPDMA_CYC_READ;
			ISA_DMA_WRITE <= cyc_kind == IPDMA_CYC_WRITE;
			ISA_DMA_VERIFY <= cyc_kind == IPDMA_CYC_VERIFY;
			ISA_DMA_TC <= dma_cycle && cyc_is_tc;
			FORWARD_TO_ISA <= next_forward;
			ISA_BUS_CLOCK <= isa_clk;
		end
	end

	wire [31:0] status = {16'h0, 2'h0, boot_test, inhibit, granted, granted_chan, passed_req};

	ipdma_axil u_axil (
		.clk(CLK),
		.rstn(RSTN),
		.awaddr(AWADDR),
		.awvalid(AWVALID),
		.awready(AWREADY),
		.wdata(WDATA),
		.wstrb(WSTRB),
		.wvalid(WVALID),
		.wready(WREADY),
		.bresp(BRESP),
		.bvalid(BVALID),
		.bready(BREADY),
		.araddr(ARADDR),
		.arvalid(ARVALID),
		.arready(ARREADY),
		.rdata(RDATA),
		.rresp(RRESP),
		.rvalid(RVALID),
		.rready(RREADY),
		.status(status),
		.ctrl(ctrl)
	);

	ipdma_clkdiv u_clkdiv (
		.clk(CLK),
		.rstn(RSTN),
		.div_code(ctrl[IPDMA_CTRL_DIV_LSB +: 3]),
		.isa_clk(isa_clk)
	);

	AST_START_ONE_CLOCK: assert property (@(posedge CLK) disable iff (!RSTN)
		(req_state == IPDMA_REQ_START) |-> !SERIAL_DMA_REQUEST_N ##1 (req_state == IPDMA_REQ_BITS))
		else $error("start marker not one clock");
	AST_EIGHT_BITS: assert property (@(posedge CLK) disable iff (!RSTN)
		(req_state == IPDMA_REQ_START) |-> ##8 (req_state == IPDMA_REQ_HOLD))
		else $error("request bits not eight clocks");
	AST_CH4_LOW: assert property (@(posedge CLK) disable iff (!RSTN)
		$rose(req_state == IPDMA_REQ_START) |-> ##5 !SERIAL_DMA_REQUEST_N)
		else $error("channel 4 bit not low");
	AST_HOLD_ASSERTED: assert property (@(posedge CLK) disable iff (!RSTN)
		(req_state == IPDMA_REQ_HOLD && any_req) |=> !SERIAL_DMA_REQUEST_N)
		else $error("request not maintained");
	AST_RESERVED_NO_ACK: assert property (@(posedge CLK) disable iff (!RSTN)
		(code_done && next_code == IPDMA_RSVD_CHANNEL) |=> !granted || $past(granted))
		else $error("reserved grant acknowledged");
	AST_ACK_ONE_HOT: assert property (@(posedge CLK) disable iff (!RSTN)
		granted |-> (ISA_DMA_ACKNOWLEDGE_N == ~(8'h01 << granted_chan)))
		else $error("acknowledge mismatch");
	AST_VERIFY_READ_ONLY: assert property (@(posedge CLK) disable iff (!RSTN)
		(IO_CYCLE_VALID && IO_CYCLE_WRITE) |=> !ISA_DMA_VERIFY)
		else $error("verify on a write");
	AST_TC_FROM_A2: assert property (@(posedge CLK) disable iff (!RSTN)
		dma_cycle |=> (ISA_DMA_TC == $past(IO_CYCLE_ADDR[2])))
		else $error("terminal count mismatch");
	AST_INHIBIT_BLOCKS: assert property (@(posedge CLK) disable iff (!RSTN)
		(inhibit && !bios_boot) |=> !FORWARD_TO_ISA)
		else $error("forward while inhibited");
endmodule : ipdma_bridge
`default_nettype wire

// ===== testbench/ipdma_arb_model.sv
// Partner model: primary DMA arbiter on the serial request and grant lines
`timescale 1ns/1ps
`default_nettype none
module ipdma_arb_model (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic req_n,
	input wire logic go,
	input wire logic [2:0] chan,
	output logic gnt_n,
	output logic [7:0] cap,
	output logic [7:0] frames
);
	logic [3:0] rc;
	logic [2:0] gc;
	logic armed;
	// Re-armed only by an idle-high line, so a high last bit cannot fake a start
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rc <= 4'h0;
			armed <= 1'b1;
			cap <= 8'h00;
			frames <= 8'h00;
		end else if (rc == 4'h0) begin
			armed <= req_n;
			rc <= (armed && !req_n) ? 4'h1 : 4'h0;
		end else begin
			cap[rc - 4'h1] <= req_n;
			rc <= (rc == 4'h8) ? 4'h0 : rc + 4'h1;
			frames <= (rc == 4'h8) ? frames + 8'h01 : frames;
		end
	end
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			gc <= 3'h0;
			gnt_n <= 1'b1;
		end else if (gc == 3'h0) begin
			gnt_n <= !go;
			gc <= go ? 3'h1 : 3'h0;
		end else begin
			gnt_n <= chan[3'h3 - gc];
			gc <= (gc == 3'h3) ? 3'h0 : gc + 3'h1;
		end
	end
endmodule : ipdma_arb_model
`default_nettype wire

// ===== testbench/tb_isa_dma_channel_passing.sv
// Testbench: request serialiser, grant decode, DMA I/O decode, boot decode, ISA clock
`timescale 1ns/1ps
`default_nettype none
module tb_isa_dma_channel_passing;
	import ipdma_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, done = 1'b0, go = 1'b0, req_n, gnt_n;
	logic iov = 1'b0, iow = 1'b0, rd, wr, vf, tc, isa_clk, fwd;
	logic mv = 1'b0, mb = 1'b0, mc = 1'b0, inh = 1'b0, bpd_n = 1'b1;
	logic [7:0] req = 8'h00, ack_n, cap, frames, awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] ioa = 32'h0, wdata = 32'h0, rdata, seed = 32'h01DCF869;
	logic [2:0] chan = 3'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int error_cnt = 0, checked = 0, cyc = 0;
	always #20 clk = ~clk;
	ipdma_bridge dut (.CLK(clk), .RSTN(rstn), .ISA_DMA_REQUEST(req),
		.SERIAL_DMA_REQUEST_N(req_n), .SERIAL_DMA_GRANT_N(gnt_n),
		.ISA_DMA_ACKNOWLEDGE_N(ack_n), .DMA_DONE(done), .IO_CYCLE_VALID(iov),
		.IO_CYCLE_WRITE(iow), .IO_CYCLE_ADDR(ioa), .ISA_DMA_READ(rd), .ISA_DMA_WRITE(wr),
		.ISA_DMA_VERIFY(vf), .ISA_DMA_TC(tc), .MEM_CYCLE_VALID(mv), .MEM_IN_BIOS_RANGE(mb),
		.MEM_CLAIMED_ELSEWHERE(mc), .SUBTRACTIVE_DECODE_INHIBIT(inh),
		.BOOT_POSITIVE_DECODE_TEST_N(bpd_n), .FORWARD_TO_ISA(fwd), .ISA_BUS_CLOCK(isa_clk),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF),
		.WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
		.ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
		.RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
	ipdma_arb_model partner (.CLK(clk), .RSTN(rstn), .req_n(req_n), .go(go), .chan(chan),
		.gnt_n(gnt_n), .cap(cap), .frames(frames));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] exp_ack(input logic [2:0] c);
		return (c == IPDMA_RSVD_CHANNEL) ? 8'hFF : ~(8'h01 << c);
	endfunction : exp_ack
	function automatic logic [3:0] exp_io(input logic [31:0] a, input logic w);
		logic n, v;
		n = (a == IPDMA_ADDR_NORMAL) || (a == IPDMA_ADDR_NORMAL_TC);
		v = !w && ((a == IPDMA_ADDR_VERIFY) || (a == IPDMA_ADDR_VERIFY_TC));
		return {n && !w, n && w, v, (n || v) && a[2]};
	endfunction : exp_io
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk) begin awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; end
		bready <= 1'b1;
		forever begin
			@(posedge clk);
			if (aw && awready) begin awvalid <= 1'b0; aw = 1'b0; end
			if (w && wready) begin wvalid <= 1'b0; w = 1'b0; end
			if (bvalid) break;
		end
		bready <= 1'b0;
		cmp(32'(bresp), 32'(IPDMA_RESP_OKAY));
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar;
		ar = 1'b1;
		@(posedge clk) begin araddr <= a; arvalid <= 1'b1; rready <= 1'b1; end
		forever begin
			@(posedge clk);
			if (ar && arready) begin arvalid <= 1'b0; ar = 1'b0; end
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axr
	task automatic io(input logic [31:0] a, input logic w, input logic g);
		@(posedge clk) begin iov <= 1'b1; ioa <= a; iow <= w; end
		@(posedge clk) iov <= 1'b0;
		@(negedge clk);
		cmp(32'({rd, wr, vf, tc}), 32'(g ? exp_io(a, w) : 4'h0));
	endtask : io
	task automatic mem(input logic b, input logic c, input logic e);
		@(posedge clk) begin mv <= 1'b1; mb <= b; mc <= c; end
		@(posedge clk) mv <= 1'b0;
		@(negedge clk);
		cmp(32'(fwd), 32'(e));
	endtask : mem
	task automatic meas(output int p);
		logic q;
		int s;
		s = 0;
		p = 0;
		q = 1'b1;
		while (s < 2) begin
			@(negedge clk);
			if (isa_clk && !q) s++;
			if (s == 1) p++;
			q = isa_clk;
		end
	endtask : meas
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] v, f;
		int p;
		tick(8);
		rstn <= 1'b1;
		tick(4);
		axr(IPDMA_REG_CTRL, d, r);
		cmp(32'(d[2:0]), 32'(IPDMA_DIV_RESET));
		axr(8'h08, d, r);
		cmp(32'(r), 32'(IPDMA_RESP_SLVERR));
		$display("register test done");
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			v = (i == 0) ? 8'h10 : (i == 1) ? 8'hFF : seed[7:0];
			f = frames;
			@(posedge clk) req <= v;
			repeat (30) if (frames == f && (v & 8'hEF) != 8'h00) @(posedge clk);
			tick(4);
			@(negedge clk);
			if ((v & 8'hEF) == 8'h00) cmp(32'(req_n), 32'h1);
			else cmp(32'(cap), 32'(v & 8'hEF));
			if ((v & 8'hEF) != 8'h00) cmp(32'(req_n), 32'h0);
			axr(IPDMA_REG_STATUS, d, r);
			cmp(32'(d[7:0]), 32'(v & 8'hEF));
			@(posedge clk) req <= 8'h00;
			tick(8);
		end
		$display("request test done");
		@(posedge clk) req <= 8'hEF;
		for (int c = 0; c < 8; c++) begin
			@(posedge clk) begin chan <= c[2:0]; go <= 1'b1; end
			@(posedge clk) go <= 1'b0;
			tick(10);
			@(negedge clk);
			cmp(32'(ack_n), 32'(exp_ack(c[2:0])));
			seed = lfsr(seed);
			for (int k = 0; k < 10; k++)
				io((k < 8) ? {24'h0, k[2] ? 8'hC0 : 8'h00} | (k[1] ? 32'h4 : 32'h0) :
					{24'h0, seed[7:2], 2'b00}, k[0], c != 4);
			@(posedge clk) done <= 1'b1;
			@(posedge clk) done <= 1'b0;
			tick(2);
			@(negedge clk);
			cmp(32'(ack_n), 32'hFF);
			io(IPDMA_ADDR_NORMAL, 1'b0, 1'b0);
		end
		$display("grant test done");
		mem(1'b0, 1'b0, 1'b1);
		@(posedge clk) inh <= 1'b1;
		tick(4);
		mem(1'b0, 1'b0, 1'b0);
		mem(1'b1, 1'b0, 1'b0);
		mem(1'b0, 1'b1, 1'b0);
		@(posedge clk) bpd_n <= 1'b0;
		tick(4);
		mem(1'b1, 1'b0, 1'b1);
		axw(IPDMA_REG_CTRL, 32'h13);
		mem(1'b1, 1'b0, 1'b0);
		@(posedge clk) inh <= 1'b0;
		tick(4);
		mem(1'b1, 1'b0, 1'b1);
		$display("decode test done");
		for (int k = 0; k < 3; k++) begin
			v = (k == 0) ? 8'h12 : (k == 1) ? 8'h13 : 8'h10;
			axw(IPDMA_REG_CTRL, 32'(v));
			tick(10);
			meas(p);
			cmp(32'(p), (v[2:0] == IPDMA_DIV3_CODE) ? 32'h3 : 32'h4);
		end
		$display("clock test done");
		conclude();
	end
endmodule : tb_isa_dma_channel_passing
`default_nettype wire
